// file: gain_offset_pkg.sv
// Package with register map, field positions, reset values and the register request type.
package gain_offset_pkg;

    // ==========================================================
    // Register addresses
    // ==========================================================
    localparam logic [7:0] ADDR_DATAPATH_CTRL = 8'h27;
    localparam logic [7:0] ADDR_OFFSET_LOW = 8'h3B;
    localparam logic [7:0] ADDR_OFFSET_HIGH = 8'h3C;
    localparam logic [7:0] ADDR_GAIN_LEVEL = 8'h3F;
    localparam logic [7:0] ADDR_RISE_INC = 8'h41;
    localparam logic [7:0] ADDR_FALL_STATE = 8'h42;
    localparam logic [7:0] ADDR_GATE_CTRL = 8'h43;
    localparam logic [7:0] ADDR_SHUTDOWN_CTRL = 8'h44;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] RST_DATAPATH_CTRL = 8'h00;
    localparam logic [7:0] RST_OFFSET_LOW = 8'h00;
    localparam logic [7:0] RST_OFFSET_HIGH = 8'h00;
    localparam logic [7:0] RST_GAIN_LEVEL = 8'h20;
    localparam logic [7:0] RST_RISE_INC = 8'h01;
    localparam logic [7:0] RST_FALL_STATE = 8'h01;
    localparam logic [7:0] RST_GATE_CTRL = 8'h07;
    localparam logic [7:0] RST_SHUTDOWN_CTRL = 8'h8F;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int BIT_SCALE_OFFSET_EN = 5;
    localparam int BIT_OUTPUT_STATUS = 7;
    localparam int BIT_OUTPUT_ON = 6;
    localparam int BIT_GATE_RAMP_EN = 2;
    localparam int BIT_GATE_SLEEP_EN = 1;
    localparam int BIT_GATE_PD_EN = 0;
    localparam int BIT_OUT_CTRL_EN = 7;
    localparam int BIT_WARN_SD_EN = 3;
    localparam int BIT_FAULT_SD_EN = 0;

    // ==========================================================
    // Gain arithmetic and timing
    // ==========================================================
    localparam int GAIN_W = 6;
    localparam int GAIN_FRAC = 5;
    localparam int STEP_FRAC = 4;
    localparam int RAMP_ACC_W = 8;
    localparam int RAMP_PERIOD = 4;
    localparam int SAMPLE_W = 16;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : gain_offset_pkg

// file: ramp_tick.sv
// Periodic strobe generator for the gain ramp.
`timescale 1ns/1ps
module ramp_tick
    import gain_offset_pkg::*;
#(
    parameter int PERIOD = RAMP_PERIOD
)
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_restart,
    output logic o_tick
);
    logic [$clog2(PERIOD)-1:0] cnt_reg;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            cnt_reg <= '0;
        else if (i_restart)
            cnt_reg <= '0;
        else if (cnt_reg == ($clog2(PERIOD))'(PERIOD - 1))
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_reg + 1'b1;
    end

    assign o_tick = (cnt_reg == ($clog2(PERIOD))'(PERIOD - 1));
endmodule : ramp_tick

// file: sample_scaler.sv
// Scales one sample by the gain, adds the offset and saturates to 16 bits.
`timescale 1ns/1ps
module sample_scaler
    import gain_offset_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_enable,
    input wire logic i_valid,
    input wire logic signed [SAMPLE_W-1:0] i_sample,
    input wire logic [GAIN_W-1:0] i_gain,
    input wire logic signed [SAMPLE_W-1:0] i_offset,
    output logic o_valid,
    output logic signed [SAMPLE_W-1:0] o_sample
);
    localparam int PROD_W = SAMPLE_W + GAIN_W + 2;
    localparam logic signed [PROD_W-1:0] MAX_V = PROD_W'(32767);
    localparam logic signed [PROD_W-1:0] MIN_V = -PROD_W'(32768);

    logic signed [PROD_W-1:0] prod;
    logic signed [PROD_W-1:0] sum;
    logic signed [SAMPLE_W-1:0] sat;

    always_comb
    begin
        prod = (PROD_W'(i_sample) * $signed({1'b0, i_gain})) >>> GAIN_FRAC;
        sum = prod + PROD_W'(i_offset);
        if (sum > MAX_V)
            sat = 16'h7FFF;
        else if (sum < MIN_V)
            sat = 16'h8000;
        else
            sat = sum[SAMPLE_W-1:0];
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_sample <= '0;
        else if (i_valid)
            o_sample <= i_enable ? sat : i_sample;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_valid <= 1'b0;
        else
            o_valid <= i_valid;
    end
endmodule : sample_scaler

// file: gain_offset_txgate.sv
// Gain, dc offset and transmit-gate control stage with its register file.
`timescale 1ns/1ps

// ==========================================================
// Top module
// ==========================================================
module gain_offset_txgate
    import gain_offset_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_transmit_gate_pin,
    input wire logic i_fifo_warning,
    input wire logic i_fifo_fault,
    input wire logic i_sample_valid,
    input wire logic [SAMPLE_W-1:0] i_sample,
    output logic o_sample_valid,
    output logic [SAMPLE_W-1:0] o_sample,
    output logic o_output_on,
    output logic o_sleep,
    output logic o_power_down
);
    // ==========================================================
    // Register file
    // ==========================================================
    reg_req_t req;
    logic [7:0] datapath_ctrl_reg;
    logic [7:0] offset_lower_byte_reg;
    logic [7:0] offset_upper_byte_reg;
    logic [7:0] gain_word_reg;
    logic [7:0] rise_inc_reg;
    logic [5:0] fall_step_reg;
    logic [7:0] gate_ctrl_reg;
    logic [7:0] shutdown_ctrl_reg;
    logic output_on_req;
    logic auto_off_reg;

    assign req = '{addr: i_reg_addr, wdata: i_reg_wdata, wr: i_reg_wr, rd: i_reg_rd};

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            datapath_ctrl_reg <= RST_DATAPATH_CTRL;
            offset_lower_byte_reg <= RST_OFFSET_LOW;
            offset_upper_byte_reg <= RST_OFFSET_HIGH;
            gain_word_reg <= RST_GAIN_LEVEL;
            rise_inc_reg <= RST_RISE_INC;
            fall_step_reg <= RST_FALL_STATE[5:0];
            gate_ctrl_reg <= RST_GATE_CTRL;
            shutdown_ctrl_reg <= RST_SHUTDOWN_CTRL;
        end
        else if (req.wr)
        begin
            case (req.addr)
                ADDR_DATAPATH_CTRL: datapath_ctrl_reg <= req.wdata & 8'hA0;
                ADDR_OFFSET_LOW: offset_lower_byte_reg <= req.wdata;
                ADDR_OFFSET_HIGH: offset_upper_byte_reg <= req.wdata;
                ADDR_GAIN_LEVEL: gain_word_reg <= req.wdata & 8'h3F;
                ADDR_RISE_INC: rise_inc_reg <= req.wdata & 8'h3F;
                ADDR_FALL_STATE: fall_step_reg <= req.wdata[5:0];
                ADDR_GATE_CTRL: gate_ctrl_reg <= req.wdata & 8'h07;
                ADDR_SHUTDOWN_CTRL: shutdown_ctrl_reg <= req.wdata & 8'h89;
                default: ;
            endcase
        end
    end

    // Manual turn-on is a one-cycle strobe; the bit always reads back zero.
    assign output_on_req = req.wr && (req.addr == ADDR_FALL_STATE)
                           && req.wdata[BIT_OUTPUT_ON];

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_reg_rdata <= 8'h00;
        else if (req.rd)
        begin
            case (req.addr)
                ADDR_DATAPATH_CTRL: o_reg_rdata <= datapath_ctrl_reg;
                ADDR_OFFSET_LOW: o_reg_rdata <= offset_lower_byte_reg;
                ADDR_OFFSET_HIGH: o_reg_rdata <= offset_upper_byte_reg;
                ADDR_GAIN_LEVEL: o_reg_rdata <= gain_word_reg;
                ADDR_RISE_INC: o_reg_rdata <= rise_inc_reg;
                ADDR_FALL_STATE: o_reg_rdata <= {auto_off_reg, 1'b0, fall_step_reg};
                ADDR_GATE_CTRL: o_reg_rdata <= gate_ctrl_reg;
                ADDR_SHUTDOWN_CTRL: o_reg_rdata <= shutdown_ctrl_reg;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_reg_rvalid <= 1'b0;
        else
            o_reg_rvalid <= req.rd;
    end

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Three stages per pin; a level changes only when stages two and three agree.
    logic [2:0] gate_sync_reg;
    logic [2:0] warn_sync_reg;
    logic [2:0] fault_sync_reg;
    logic gate_lvl_reg;
    logic warn_lvl_reg;
    logic fault_lvl_reg;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            gate_sync_reg <= 3'b000;
            warn_sync_reg <= 3'b000;
            fault_sync_reg <= 3'b000;
        end
        else
        begin
            gate_sync_reg <= {gate_sync_reg[1:0], i_transmit_gate_pin};
            warn_sync_reg <= {warn_sync_reg[1:0], i_fifo_warning};
            fault_sync_reg <= {fault_sync_reg[1:0], i_fifo_fault};
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            gate_lvl_reg <= 1'b0;
            warn_lvl_reg <= 1'b0;
            fault_lvl_reg <= 1'b0;
        end
        else
        begin
            if (gate_sync_reg[1] == gate_sync_reg[2])
                gate_lvl_reg <= gate_sync_reg[2];
            if (warn_sync_reg[1] == warn_sync_reg[2])
                warn_lvl_reg <= warn_sync_reg[2];
            if (fault_sync_reg[1] == fault_sync_reg[2])
                fault_lvl_reg <= fault_sync_reg[2];
        end
    end

    logic gate_prev_reg;
    logic gate_rise;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            gate_prev_reg <= 1'b0;
        else
            gate_prev_reg <= gate_lvl_reg;
    end

    assign gate_rise = gate_lvl_reg && !gate_prev_reg;

    // ==========================================================
    // Automatic shutdown
    // ==========================================================
    logic ctrl_en;
    logic shutdown_event;

    assign ctrl_en = shutdown_ctrl_reg[BIT_OUT_CTRL_EN];
    assign shutdown_event = ctrl_en
        && ((shutdown_ctrl_reg[BIT_WARN_SD_EN] && warn_lvl_reg)
            || (shutdown_ctrl_reg[BIT_FAULT_SD_EN] && fault_lvl_reg));

    // A persisting FIFO condition wins over the manual turn-on.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            auto_off_reg <= 1'b0;
        else if (shutdown_event)
            auto_off_reg <= 1'b1;
        else if (output_on_req)
            auto_off_reg <= 1'b0;
    end

    // ==========================================================
    // Gain ramp
    // ==========================================================
    // Applied gain keeps the five fraction bits of the gain word, so an odd gain word is
    // reached exactly; the steps carry one fraction bit fewer and are doubled to match.
    typedef enum logic [1:0] {RAMP_IDLE, RAMP_UP, RAMP_DOWN} ramp_state_t;

    ramp_state_t ramp_reg;
    logic [RAMP_ACC_W-1:0] applied_reg;
    logic [RAMP_ACC_W-1:0] target;
    logic [RAMP_ACC_W-1:0] rise_step;
    logic [RAMP_ACC_W-1:0] fall_step;
    logic tick;
    logic restart;
    logic ramp_en;
    logic want_on;
    logic [GAIN_W-1:0] gain_applied;

    assign ramp_en = gate_ctrl_reg[BIT_GATE_RAMP_EN];
    assign want_on = (!ramp_en || gate_lvl_reg) && !auto_off_reg;
    assign restart = (ramp_en && gate_rise) || output_on_req;
    assign target = {2'b00, gain_word_reg[GAIN_W-1:0]};
    assign rise_step = {1'b0, rise_inc_reg[5:0], 1'b0};
    assign fall_step = {1'b0, fall_step_reg, 1'b0};

    ramp_tick #(
        .PERIOD(RAMP_PERIOD)
    ) u_tick (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_restart(restart),
        .o_tick(tick)
    );

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ramp_reg <= RAMP_IDLE;
            applied_reg <= {2'b00, RST_GAIN_LEVEL[GAIN_W-1:0]};
        end
        else if (!ramp_en)
        begin
            ramp_reg <= RAMP_IDLE;
            applied_reg <= auto_off_reg ? 8'h00 : target;
        end
        else if (restart)
        begin
            ramp_reg <= RAMP_UP;
            applied_reg <= 8'h00;
        end
        else
        begin
            case (ramp_reg)
                RAMP_IDLE:
                begin
                    if (!want_on && applied_reg != 8'h00)
                        ramp_reg <= RAMP_DOWN;
                    else if (want_on && applied_reg != target)
                        applied_reg <= target;
                end
                RAMP_UP:
                begin
                    if (!want_on)
                        ramp_reg <= RAMP_DOWN;
                    else if (tick)
                    begin
                        if (applied_reg + rise_step >= target)
                        begin
                            applied_reg <= target;
                            ramp_reg <= RAMP_IDLE;
                        end
                        else
                            applied_reg <= applied_reg + rise_step;
                    end
                end
                RAMP_DOWN:
                begin
                    if (tick)
                    begin
                        if (applied_reg <= fall_step)
                        begin
                            applied_reg <= 8'h00;
                            ramp_reg <= RAMP_IDLE;
                        end
                        else
                            applied_reg <= applied_reg - fall_step;
                    end
                end
                default: ramp_reg <= RAMP_IDLE;
            endcase
        end
    end

    // The clamp is a guard only; the ramp never leaves the six-bit range.
    assign gain_applied = (applied_reg > 8'h3F) ? 6'h3F : applied_reg[GAIN_W-1:0];

    // ==========================================================
    // Datapath and power states
    // ==========================================================
    sample_scaler u_scaler (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_enable(datapath_ctrl_reg[BIT_SCALE_OFFSET_EN]),
        .i_valid(i_sample_valid),
        .i_sample(i_sample),
        .i_gain(gain_applied),
        .i_offset({offset_upper_byte_reg, offset_lower_byte_reg}),
        .o_valid(o_sample_valid),
        .o_sample(o_sample)
    );

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_output_on <= 1'b0;
            o_sleep <= 1'b0;
            o_power_down <= 1'b0;
        end
        else
        begin
            o_output_on <= !auto_off_reg;
            o_sleep <= gate_ctrl_reg[BIT_GATE_SLEEP_EN] && !gate_lvl_reg;
            o_power_down <= gate_ctrl_reg[BIT_GATE_PD_EN] && !gate_lvl_reg;
        end
    end
endmodule : gain_offset_txgate

// file: gain_offset_txgate_properties.sv
// Checker with concurrent properties for the gain, offset and gate stage.
`timescale 1ns/1ps
// ====================
// Properties
// ====================
module gain_offset_txgate_properties
    import gain_offset_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic i_transmit_gate_pin,
    input wire logic i_fifo_warning,
    input wire logic i_fifo_fault,
    input wire logic i_sample_valid,
    input wire logic [SAMPLE_W-1:0] i_sample,
    input wire logic o_sample_valid,
    input wire logic [SAMPLE_W-1:0] o_sample,
    input wire logic o_output_on,
    input wire logic o_sleep,
    input wire logic o_power_down
);
    logic [2:0] since_on;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // Saturates so a turn-on write long ago never looks recent again.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            since_on <= 3'h7;
        else if (i_reg_wr && i_reg_addr == ADDR_FALL_STATE && i_reg_wdata[BIT_OUTPUT_ON])
            since_on <= 3'h0;
        else if (since_on != 3'h7)
            since_on <= since_on + 3'h1;
    end
    rd_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    rvalid_only_a: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("read answer without a read");
    gain_width_a: assert property (i_reg_rd && i_reg_addr == ADDR_GAIN_LEVEL
        |=> o_reg_rdata[7:6] == 2'h0) else $error("gain word wider than six bits");
    turnon_reads_a: assert property (i_reg_rd && i_reg_addr == ADDR_FALL_STATE
        |=> !o_reg_rdata[BIT_OUTPUT_ON]) else $error("turn-on bit reads one");
    shut_bits_a: assert property (i_reg_rd && i_reg_addr == ADDR_SHUTDOWN_CTRL
        |=> o_reg_rdata[6:4] == 3'h0) else $error("bad bits");
    sample_lat_a: assert property (i_sample_valid |=> o_sample_valid)
        else $error("sample not answered next cycle");
    sample_hold_a: assert property (!o_sample_valid |-> $stable(o_sample))
        else $error("output sample moved without valid");
    gate_wake_a: assert property (i_transmit_gate_pin [*8]
        |-> !o_sleep && !o_power_down) else $error("low-power state with gate high");
    no_cause_a: assert property ((!i_fifo_warning && !i_fifo_fault) [*8]
        |=> !$fell(o_output_on)) else $error("output shut without cause");
    turnon_src_a: assert property ($rose(o_output_on) && $past(i_nrst, 2)
        |-> since_on <= 3'h3) else $error("output on without turn-on write");
endmodule : gain_offset_txgate_properties

bind gain_offset_txgate gain_offset_txgate_properties u_props (.i_clk, .i_nrst, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_transmit_gate_pin,
    .i_fifo_warning, .i_fifo_fault, .i_sample_valid, .i_sample, .o_sample_valid, .o_sample,
    .o_output_on, .o_sleep, .o_power_down);

// file: sample_source.sv
// Upstream sample source and transmit-gate level driver.
`timescale 1ns/1ps
// ====================
// Partner model
// ====================
module sample_source
(
    input wire logic i_clk,
    output logic o_valid,
    output logic [15:0] o_sample,
    output logic o_gate,
    output logic o_warn,
    output logic o_fault
);
    logic [15:0] dat;
    int cnt;
    initial
    begin
        {o_valid, o_gate, o_warn, o_fault} = 4'h0;
        o_sample = 16'h0000;
        dat = 16'h0000;
        cnt = 0;
    end
    // Idle sample lines toggle so a stale word never passes for fresh data.
    always @(negedge i_clk)
    begin
        o_valid <= cnt > 0;
        o_sample <= (cnt > 0) ? dat : ~o_sample;
        if (cnt > 0)
            cnt <= cnt - 1;
    end
    task stream(input logic [15:0] s, input int n);
        @(posedge i_clk);
        dat <= s;
        cnt <= n;
    endtask : stream
    task levels(input logic g, input logic w, input logic f);
        @(negedge i_clk);
        o_gate <= g;
        o_warn <= w;
        o_fault <= f;
    endtask : levels
endmodule : sample_source

// file: tb_top.sv
// Self-checking testbench for the gain, offset and gate stage.
`timescale 1ns/1ps
// ====================
// Testbench
// ====================
module tb_top;
    import gain_offset_pkg::*;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [7:0] o_reg_rdata;
    logic o_reg_rvalid;
    logic i_transmit_gate_pin, i_fifo_warning, i_fifo_fault, i_sample_valid;
    logic [15:0] i_sample;
    logic [15:0] o_sample;
    logic o_sample_valid, o_output_on, o_sleep, o_power_down;
    int n_fail = 0;
    int checked = 0;
    logic [7:0] ra [8] = '{ADDR_DATAPATH_CTRL, ADDR_OFFSET_LOW, ADDR_OFFSET_HIGH,
        ADDR_GAIN_LEVEL, ADDR_RISE_INC, ADDR_FALL_STATE, ADDR_GATE_CTRL, ADDR_SHUTDOWN_CTRL};
    logic [7:0] rv [8] = '{RST_DATAPATH_CTRL, RST_OFFSET_LOW, RST_OFFSET_HIGH,
        RST_GAIN_LEVEL, RST_RISE_INC, RST_FALL_STATE, RST_GATE_CTRL, RST_SHUTDOWN_CTRL};
    always #2.5 i_clk = ~i_clk;
    gain_offset_txgate i_gain_offset_txgate (.i_clk, .i_nrst, .i_reg_addr, .i_reg_wdata,
        .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_transmit_gate_pin,
        .i_fifo_warning, .i_fifo_fault, .i_sample_valid, .i_sample, .o_sample_valid,
        .o_sample, .o_output_on, .o_sleep, .o_power_down);
    sample_source src (.i_clk, .o_valid(i_sample_valid), .o_sample(i_sample),
        .o_gate(i_transmit_gate_pin), .o_warn(i_fifo_warning), .o_fault(i_fifo_fault));
    task chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_clk);
        i_reg_rd = 1'b0;
        chk({15'h0000, o_reg_rvalid}, 16'h0001);
        chk({8'h00, o_reg_rdata}, {8'h00, e});
    endtask : rd
    task smp(input logic [15:0] s, input logic [15:0] e);
        int k;
        k = 0;
        src.stream(s, 1);
        while (o_sample_valid !== 1'b1 && k < 6)
        begin
            @(negedge i_clk);
            k++;
        end
        chk(o_sample, e);
    endtask : smp
    task sc(input logic [7:0] g, hi, lo, input logic [15:0] s, e);
        wr(ADDR_GAIN_LEVEL, g);
        wr(ADDR_OFFSET_HIGH, hi);
        wr(ADDR_OFFSET_LOW, lo);
        smp(s, e);
    endtask : sc
    task flags(input logic on, sl, pd);
        chk({13'h0000, o_output_on, o_sleep, o_power_down}, {13'h0000, on, sl, pd});
    endtask : flags
    task partial();
        chk({15'h0000, o_sample != 16'h0000 && o_sample < 16'h1000}, 16'h0001);
    endtask : partial
    task conclude();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    initial
    begin
        #20000;
        n_fail++;
        conclude();
    end
    initial
    begin
        cyc(2);
        i_nrst = 1'b1;
        for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
        rd(8'h50, 8'h00);
        flags(1'b1, 1'b1, 1'b1);
        src.levels(1'b1, 1'b0, 1'b0);
        cyc(10);
        flags(1'b1, 1'b0, 1'b0);
        wr(ADDR_GATE_CTRL, 8'h02);
        src.levels(1'b0, 1'b0, 1'b0);
        cyc(10);
        flags(1'b1, 1'b1, 1'b0);
        wr(ADDR_GATE_CTRL, 8'h01);
        cyc(3);
        flags(1'b1, 1'b0, 1'b1);
        wr(ADDR_GAIN_LEVEL, 8'hFF);
        rd(ADDR_GAIN_LEVEL, 8'h3F);
        wr(ADDR_FALL_STATE, 8'hC5);
        rd(ADDR_FALL_STATE, 8'h05);
        wr(ADDR_GATE_CTRL, 8'hFF);
        rd(ADDR_GATE_CTRL, 8'h07);
        wr(ADDR_SHUTDOWN_CTRL, 8'hFF);
        rd(ADDR_SHUTDOWN_CTRL, 8'h89);
        wr(ADDR_SHUTDOWN_CTRL, 8'h8F);
        smp(16'h1234, 16'h1234);
        wr(ADDR_GATE_CTRL, 8'h00);
        wr(ADDR_DATAPATH_CTRL, 8'h20);
        sc(8'h20, 8'h01, 8'h00, 16'h1000, 16'h1100);
        sc(8'h10, 8'h00, 8'h34, 16'h1000, 16'h0834);
        sc(8'h3F, 8'h00, 8'h00, 16'h7000, 16'h7FFF);
        sc(8'h3F, 8'h00, 8'h00, 16'h9000, 16'h8000);
        sc(8'h20, 8'hFF, 8'hFF, 16'h0000, 16'hFFFF);
        sc(8'h20, 8'h80, 8'h00, 16'h8000, 16'h8000);
        wr(ADDR_OFFSET_HIGH, 8'h00);
        wr(ADDR_RISE_INC, 8'h01);
        wr(ADDR_FALL_STATE, 8'h01);
        wr(ADDR_GATE_CTRL, 8'h04);
        cyc(100);
        src.stream(16'h1000, 1000);
        cyc(4);
        chk(o_sample, 16'h0000);
        src.levels(1'b1, 1'b0, 1'b0);
        cyc(16);
        partial();
        cyc(80);
        chk(o_sample, 16'h1000);
        src.levels(1'b1, 1'b1, 1'b0);
        cyc(8);
        flags(1'b0, 1'b0, 1'b0);
        rd(ADDR_FALL_STATE, 8'h81);
        cyc(80);
        chk(o_sample, 16'h0000);
        wr(ADDR_FALL_STATE, 8'h41);
        cyc(4);
        flags(1'b0, 1'b0, 1'b0);
        src.levels(1'b1, 1'b0, 1'b0);
        cyc(6);
        wr(ADDR_FALL_STATE, 8'h41);
        cyc(3);
        flags(1'b1, 1'b0, 1'b0);
        cyc(8);
        partial();
        rd(ADDR_FALL_STATE, 8'h01);
        cyc(80);
        chk(o_sample, 16'h1000);
        wr(ADDR_SHUTDOWN_CTRL, 8'h09);
        src.levels(1'b1, 1'b1, 1'b1);
        cyc(10);
        flags(1'b1, 1'b0, 1'b0);
        wr(ADDR_SHUTDOWN_CTRL, 8'h81);
        src.levels(1'b1, 1'b0, 1'b1);
        cyc(10);
        flags(1'b0, 1'b0, 1'b0);
        conclude();
    end
endmodule : tb_top
